//--- bench/rcsr_host_model.sv
// Microcomputer model driving the register pins of the control block
`timescale 1ns/10ps

module rcsr_host_model (
    input  wire logic            clock_in,
    input  wire logic [3:0]      data_in,
    output rcsr_pkg::rcsr_pins_s pins_out,
    output logic                 data_oe_out
);
    initial begin
        pins_out = '{ale: 1'b0, cs0_n: 1'b1, cs1: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
                     addr: 4'h0, data: 4'h0};
        data_oe_out = 1'b0;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clock_in);
    endtask

    // ==========================================================
    // Address phase through the latch
    task automatic select_reg(input logic [3:0] a);
        @(posedge clock_in);
        pins_out.addr  <= a;
        pins_out.ale   <= 1'b1;
        pins_out.cs0_n <= 1'b0;
        cyc(2);
        pins_out.ale   <= 1'b0;
    endtask

    // Data held well past the strobe: the block samples it through two flops
    task automatic write_reg(input logic [3:0] a, input logic [3:0] d);
        select_reg(a);
        pins_out.data  <= d;
        data_oe_out    <= 1'b1;
        pins_out.wr_n  <= 1'b0;
        cyc(3);
        pins_out.wr_n  <= 1'b1;
        cyc(3);
        data_oe_out    <= 1'b0;
        pins_out.cs0_n <= 1'b1;
        cyc(8);
    endtask

    task automatic read_reg(input logic [3:0] a, output logic [3:0] d);
        select_reg(a);
        pins_out.rd_n  <= 1'b0;
        cyc(5);
        d = data_in;
        pins_out.rd_n  <= 1'b1;
        pins_out.cs0_n <= 1'b1;
        cyc(4);
    endtask

    task automatic set_power(input logic b);
        @(posedge clock_in);
        pins_out.cs1 <= b;
    endtask

    // ==========================================================
    // Hold request with retry on busy; flag written as 1 to keep it
    task automatic take_hold(output logic ok);
        logic [3:0] v;
        ok = 1'b0;
        for (int i = 0; i < 4 && !ok; i++) begin
            write_reg(4'hd, 4'h4);
            write_reg(4'hd, 4'h5);
            read_reg(4'hd, v);
            ok = (v[1] === 1'b0);
        end
    endtask
endmodule // rcsr_host_model

//--- bench/test_rtc_control_status_regs.sv
// Self-checking bench for the control and status registers
`timescale 1ns/10ps
`include "rcsr_params.svh"

module test_rtc_control_status_regs;
    localparam int TICK   = 4;
    localparam int BUSY   = 20;
    localparam int ADJ    = 40;
    localparam int PULSE  = 40;
    localparam int EV_CYC = TICK * 512; // 1/64 s in clock cycles (512 oscillator ticks)

    logic                 clock_in;
    logic                 sys_rst_in;
    rcsr_pkg::rcsr_pins_s pins;
    logic [3:0]           dut_d;
    logic [3:0]           bus_d;
    logic                 dut_oe;
    logic                 host_oe;
    logic                 pin_o;
    logic                 pin_oe;
    logic                 h24;
    logic                 tst;
    logic                 ok;
    int                   errors;
    int                   n_tests;
    int                   cycles;
    int                   w;
    int                   g;

    // Undriven data lines show the inverse of the last value, not a hold
    assign bus_d = dut_oe ? dut_d : (host_oe ? pins.data : ~pins.data);

    rcsr_host_model host_u (
        .clock_in    (clock_in),
        .data_in     (bus_d),
        .pins_out    (pins),
        .data_oe_out (host_oe)
    );

    rcsr_top #(.TICK_CYC(TICK), .BUSY_CYC(BUSY), .ADJ_CYC(ADJ), .PULSE_CYC(PULSE)) dut_u (
        .clock_in                   (clock_in),
        .sys_rst_in                 (sys_rst_in),
        .bus_ale_in                 (pins.ale),
        .bus_cs0_n_in               (pins.cs0_n),
        .power_good_select_in       (pins.cs1),
        .bus_rd_n_in                (pins.rd_n),
        .bus_wr_n_in                (pins.wr_n),
        .bus_addr_in                (pins.addr),
        .bus_data_in                (bus_d),
        .bus_data_out               (dut_d),
        .bus_data_oe_out            (dut_oe),
        .periodic_output_pin_out    (pin_o),
        .periodic_output_pin_oe_out (pin_oe),
        .hour_format_24_out         (h24),
        .test_mode_out              (tst)
    );

    initial begin
        clock_in = 1'b0;
        forever #2.5 clock_in = ~clock_in;
    end

    // ==========================================================
    // Shared checks
    task automatic finish_test;
        $display("checks %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic rchk(input logic [3:0] a, input logic [3:0] exp, input string what);
        logic [3:0] v;
        host_u.read_reg(a, v);
        chk(what, exp, v);
    endtask

    task automatic wait_pin(input logic lvl, input int lim, output int n);
        n = 0;
        while (pin_oe !== lvl && n < lim) begin
            @(posedge clock_in);
            n++;
        end
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset;
        rchk(`RCSR_ADDR_CD, 4'h2, "cd reset");
        rchk(`RCSR_ADDR_CE, `RCSR_CE_RST, "ce reset");
        rchk(`RCSR_ADDR_CF, `RCSR_CF_RST, "cf reset");
        chk("pin at reset", 0, pin_oe);
        chk("pin level", 0, pin_o);
    endtask

    task automatic t_hold;
        host_u.take_hold(ok);
        chk("hold grant", 1, ok);
        rchk(`RCSR_ADDR_CD, 4'h1, "cd held");
        host_u.write_reg(`RCSR_ADDR_CD, 4'h7);
        rchk(`RCSR_ADDR_CD, 4'h1, "busy write");
        host_u.write_reg(`RCSR_ADDR_CE, 4'h9);
        rchk(`RCSR_ADDR_CE, 4'h9, "ce in hold");
        host_u.write_reg(`RCSR_ADDR_CF, 4'h1);
        rchk(`RCSR_ADDR_CF, 4'h1, "cf in hold");
        host_u.set_power(1'b0);
        repeat (8) @(posedge clock_in);
        host_u.set_power(1'b1);
        repeat (8) @(posedge clock_in);
        rchk(`RCSR_ADDR_CD, 4'h2, "hold after drop");
        rchk(`RCSR_ADDR_CF, 4'h0, "clear after drop");
        host_u.write_reg(`RCSR_ADDR_CE, 4'h1);
    endtask

    // Format bit only moves while the divider clear is already set
    task automatic t_hour;
        host_u.write_reg(`RCSR_ADDR_CF, 4'h4);
        chk("format refused", 0, h24);
        host_u.write_reg(`RCSR_ADDR_CF, 4'h1);
        host_u.write_reg(`RCSR_ADDR_CF, 4'h5);
        host_u.write_reg(`RCSR_ADDR_CF, 4'h4);
        chk("format 24h", 1, h24);
        // Calendar hours digit lives outside this block; rewrite must not disturb control
        host_u.write_reg(4'h4, 4'h0);
        rchk(`RCSR_ADDR_CF, 4'h4, "cf format");
        chk("test bit", 0, tst);
    endtask

    task automatic t_round;
        host_u.write_reg(`RCSR_ADDR_CD, 4'hc);
        rchk(`RCSR_ADDR_CD, 4'ha, "round running");
        repeat (ADJ) @(posedge clock_in);
        rchk(`RCSR_ADDR_CD, 4'h2, "round done");
    endtask

    task automatic t_irq;
        host_u.write_reg(`RCSR_ADDR_CE, 4'h2);
        wait_pin(1'b1, EV_CYC + 200, w);
        chk("irq raised", 1, pin_oe);
        rchk(`RCSR_ADDR_CD, 4'h6, "flag set");
        repeat (EV_CYC + 100) @(posedge clock_in);
        chk("irq held", 1, pin_oe);
        host_u.write_reg(`RCSR_ADDR_CD, 4'h0);
        chk("irq cleared", 0, pin_oe);
        rchk(`RCSR_ADDR_CD, 4'h2, "flag clear");
        host_u.write_reg(`RCSR_ADDR_CE, 4'h3);
        wait_pin(1'b1, EV_CYC + 200, w);
        chk("masked", 0, pin_oe);
    endtask

    // Period measured rise to rise, so it is exact in ticks
    task automatic t_pulse;
        host_u.write_reg(`RCSR_ADDR_CE, 4'h0);
        wait_pin(1'b1, EV_CYC + 200, w);
        wait_pin(1'b0, PULSE + 20, w);
        wait_pin(1'b1, EV_CYC + 200, g);
        chk("pulse width", 1, w >= PULSE - 1 && w <= PULSE + 1);
        chk("pulse period", EV_CYC, w + g);
        host_u.write_reg(`RCSR_ADDR_CD, 4'h0);
        chk("pulse cut", 0, pin_oe);
        host_u.write_reg(`RCSR_ADDR_CE, 4'h1);
    endtask

    // Stop freezes the chain, so no 1/64 s event may reach the pin
    task automatic t_stop;
        host_u.write_reg(`RCSR_ADDR_CF, 4'h2);
        host_u.write_reg(`RCSR_ADDR_CE, 4'h2);
        wait_pin(1'b1, EV_CYC + 200, w);
        chk("stopped chain", 0, pin_oe);
        host_u.write_reg(`RCSR_ADDR_CF, 4'h0);
        wait_pin(1'b1, EV_CYC + 200, w);
        chk("chain resumed", 1, pin_oe);
        host_u.write_reg(`RCSR_ADDR_CD, 4'h0);
        host_u.write_reg(`RCSR_ADDR_CE, 4'h1);
    endtask

    // ==========================================================
    // Main sequence and hang guard
    always @(posedge clock_in) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            errors++;
            finish_test();
        end
    end

    initial begin
        errors     = 0;
        n_tests    = 0;
        cycles     = 0;
        sys_rst_in = 1'b1;
        repeat (6) @(posedge clock_in);
        sys_rst_in <= 1'b0;
        repeat (4) @(posedge clock_in);
        t_reset();
        t_hold();
        t_hour();
        t_round();
        t_irq();
        t_pulse();
        t_stop();
        finish_test();
    end
endmodule // test_rtc_control_status_regs

//--- design/rcsr_mod_counter.sv
// Modulo counter stage with carry out
`timescale 1ns/10ps

module rcsr_mod_counter #(
    parameter int unsigned   W    = 6,
    parameter logic [W-1:0]  LAST = '1
) (
    input  wire logic         clock_in,
    input  wire logic         sys_rst_in,
    input  wire logic         clear_in,
    input  wire logic         step_in,
    output logic [W-1:0]      count_out,
    output logic              carry_out
);

    assign carry_out = step_in & (count_out == LAST);

    always_ff @(posedge clock_in) begin
        if (sys_rst_in || clear_in) begin
            count_out <= '0;
        end else if (carry_out) begin
            count_out <= '0;
        end else if (step_in) begin
            count_out <= count_out + W'(1);
        end
    end

endmodule // rcsr_mod_counter

//--- design/rcsr_params.svh
// Constants for the calendar clock control and status registers
`ifndef RCSR_PARAMS_SVH
`define RCSR_PARAMS_SVH

// ==========================================================================
// Register addresses on the 4-bit address bus
`define RCSR_ADDR_CD      4'hd
`define RCSR_ADDR_CE      4'he
`define RCSR_ADDR_CF      4'hf

// ==========================================================================
// Field positions in the hold and busy register
`define RCSR_CD_HOLD      0
`define RCSR_CD_BUSY      1
`define RCSR_CD_IRQ       2
`define RCSR_CD_ADJ       3

// ==========================================================================
// Reset values
`define RCSR_CE_RST       4'h1
`define RCSR_CF_RST       4'h0

// ==========================================================================
// Counter limits
`define RCSR_SEC_LAST     6'h3b
`define RCSR_MIN_LAST     6'h3b
`define RCSR_ROUND_SEC    6'h1e

// ==========================================================================
// Timing
`define RCSR_CLK_HZ       200000000
`define RCSR_CLK_MHZ      200
`define RCSR_OSC_HZ       32768
`define RCSR_BUSY_NS      190000
`define RCSR_ADJ_NS       125000
`define RCSR_PULSE_NS     7812500
`define RCSR_TICK_CYC     (`RCSR_CLK_HZ / `RCSR_OSC_HZ)
`define RCSR_BUSY_CYC     ((`RCSR_BUSY_NS * `RCSR_CLK_MHZ) / 1000)
`define RCSR_ADJ_CYC      ((`RCSR_ADJ_NS * `RCSR_CLK_MHZ) / 1000)
`define RCSR_PULSE_CYC    ((`RCSR_PULSE_NS * `RCSR_CLK_MHZ) / 1000)

`endif

//--- design/rcsr_pkg.sv
// Types for the calendar clock control and status registers
package rcsr_pkg;

    // Bus pins as one bundle for the synchroniser
    typedef struct packed {
        logic       ale;
        logic       cs0_n;
        logic       cs1;
        logic       rd_n;
        logic       wr_n;
        logic [3:0] addr;
        logic [3:0] data;
    } rcsr_pins_s;

    // Periodic output control, bit 3 down to bit 0
    typedef struct packed {
        logic per_hi;
        logic per_lo;
        logic irq_mode;
        logic mask;
    } rcsr_ce_s;

    // Counter mode control, bit 3 down to bit 0
    typedef struct packed {
        logic test;
        logic hour24;
        logic stop;
        logic clr;
    } rcsr_cf_s;

    // Hold arbitration, Gray coded
    typedef enum logic [1:0] {
        HS_FREE   = 2'b00,
        HS_DENIED = 2'b01,
        HS_GRANT  = 2'b11
    } rcsr_hold_e;

endpackage

//--- design/rcsr_top.sv
// Control and status registers of the calendar clock
`timescale 1ns/10ps
`include "rcsr_params.svh"

module rcsr_top #(
    parameter int TICK_CYC  = `RCSR_TICK_CYC,
    parameter int BUSY_CYC  = `RCSR_BUSY_CYC,
    parameter int ADJ_CYC   = `RCSR_ADJ_CYC,
    parameter int PULSE_CYC = `RCSR_PULSE_CYC
) (
    input  wire logic       clock_in,
    input  wire logic       sys_rst_in,
    input  wire logic       bus_ale_in,
    input  wire logic       bus_cs0_n_in,
    input  wire logic       power_good_select_in,
    input  wire logic       bus_rd_n_in,
    input  wire logic       bus_wr_n_in,
    input  wire logic [3:0] bus_addr_in,
    input  wire logic [3:0] bus_data_in,
    output logic [3:0]      bus_data_out,
    output logic            bus_data_oe_out,
    output logic            periodic_output_pin_out,
    output logic            periodic_output_pin_oe_out,
    output logic            hour_format_24_out,
    output logic            test_mode_out
);

    // ======================================================================
    // Pin synchroniser and bus decode
    rcsr_pkg::rcsr_pins_s  p1;
    rcsr_pkg::rcsr_pins_s  p2;
    logic                  wr_q;
    logic [3:0]            addr_l;
    logic                  sel_l;
    wire rcsr_pkg::rcsr_pins_s pin_now = {bus_ale_in, bus_cs0_n_in, power_good_select_in,
                                          bus_rd_n_in, bus_wr_n_in, bus_addr_in, bus_data_in};

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            p1 <= '0;
            p2 <= '0;
            wr_q <= 1'b1;
        end else begin
            p1 <= pin_now;
            p2 <= p1;
            wr_q <= p2.wr_n;
        end
    end

    // Address and select latch while ALE is high
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            addr_l <= 4'h0;
            sel_l <= 1'b0;
        end else if (p2.ale) begin
            addr_l <= p2.addr;
            sel_l <= !p2.cs0_n;
        end
    end

    wire       sel     = sel_l & p2.cs1;
    wire       wr_rise = sel & p2.wr_n & !wr_q;
    wire [3:0] wd      = p2.data;
    // Control registers answer whatever the hold state
    wire       wr_cd   = wr_rise & (addr_l == `RCSR_ADDR_CD);
    wire       wr_ce   = wr_rise & (addr_l == `RCSR_ADDR_CE);
    wire       wr_cf   = wr_rise & (addr_l == `RCSR_ADDR_CF);
    wire       rd_hit  = sel & !p2.rd_n & (addr_l >= `RCSR_ADDR_CD);

    // ======================================================================
    // Control registers
    rcsr_pkg::rcsr_ce_s  ce;
    rcsr_pkg::rcsr_cf_s  cf;

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            ce <= rcsr_pkg::rcsr_ce_s'(`RCSR_CE_RST);
        end else if (wr_ce) begin
            ce <= rcsr_pkg::rcsr_ce_s'(wd);
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            cf <= rcsr_pkg::rcsr_cf_s'(`RCSR_CF_RST);
        end else if (!p2.cs1) begin
            cf.clr <= 1'b0;
        end else if (wr_cf) begin
            cf.clr <= wd[0];
            cf.stop <= wd[1];
            cf.test <= wd[3];
            // Format latches only while the divider clear is already set
            if (cf.clr) begin
                cf.hour24 <= wd[2];
            end
        end
    end

    assign hour_format_24_out = cf.hour24;
    assign test_mode_out = cf.test;

    // ======================================================================
    // Oscillator tick and sub-second divider
    logic [12:0]  tick_cnt;
    logic [14:0]  sub;
    logic [14:0]  adj_cnt;
    wire          adj_busy = adj_cnt != 15'h0;
    wire          tick     = tick_cnt == 13'(TICK_CYC - 1);
    wire          sub_hold = cf.clr | adj_busy;
    wire          sub_run  = tick & (sub[1:0] == 2'h3) & !cf.stop;
    wire          ev_64    = sub_run & (&sub[8:2]) & !sub_hold;
    wire          ev_sec   = sub_run & (&sub[14:2]) & !sub_hold;

    always_ff @(posedge clock_in) begin
        if (sys_rst_in || tick) begin
            tick_cnt <= 13'h0;
        end else begin
            tick_cnt <= tick_cnt + 13'h1;
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in || sub_hold) begin
            sub <= 15'h0;
        end else if (tick) begin
            sub[1:0] <= sub[1:0] + 2'h1;
            // 8192 Hz stage and above freeze under stop
            if (sub_run) begin
                sub[14:2] <= sub[14:2] + 13'h1;
            end
        end
    end

    // ======================================================================
    // Hold and busy arbitration
    rcsr_pkg::rcsr_hold_e  hstate;
    rcsr_pkg::rcsr_hold_e  next_hstate;
    logic                  hold_q;
    logic                  pending;
    logic [15:0]           win_cnt;
    wire                   win_busy  = win_cnt != 16'h0;
    wire                   hold      = hstate != rcsr_pkg::HS_FREE;
    wire                   busy      = hstate != rcsr_pkg::HS_GRANT;
    wire                   hold_fall = hold_q & !hold;
    // One stalled carry is replayed on release, later ones dropped
    wire                   sec_step  = (ev_sec & !hold) | (hold_fall & pending);

    always_comb begin
        next_hstate = hstate;
        if (!p2.cs1) begin
            next_hstate = rcsr_pkg::HS_FREE;
        end else if (wr_cd) begin
            if (!wd[`RCSR_CD_HOLD]) begin
                next_hstate = rcsr_pkg::HS_FREE;
            end else if (hstate == rcsr_pkg::HS_FREE) begin
                // Denied stays denied until the host writes 0 then 1 again
                next_hstate = win_busy ? rcsr_pkg::HS_DENIED : rcsr_pkg::HS_GRANT;
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            hstate <= rcsr_pkg::HS_FREE;
            hold_q <= 1'b0;
        end else begin
            hstate <= next_hstate;
            hold_q <= hold;
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in || !hold) begin
            pending <= 1'b0;
        end else if (ev_sec) begin
            pending <= 1'b1;
        end
    end

    // Busy window opens on each seconds carry
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            win_cnt <= 16'h0;
        end else if (ev_sec) begin
            win_cnt <= 16'(BUSY_CYC);
        end else if (win_busy) begin
            win_cnt <= win_cnt - 16'h1;
        end
    end

    // ======================================================================
    // Half-minute rounding and the seconds and minutes digits
    logic [5:0]  sec_val;
    logic        sec_carry;
    logic        hour_carry;
    wire         adj_start = wr_cd & wd[`RCSR_CD_ADJ] & !adj_busy;
    wire         round_up  = adj_start & (sec_val >= `RCSR_ROUND_SEC);
    wire         min_step  = sec_carry | round_up;

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            adj_cnt <= 15'h0;
        end else if (adj_start) begin
            adj_cnt <= 15'(ADJ_CYC);
        end else if (adj_busy) begin
            adj_cnt <= adj_cnt - 15'h1;
        end
    end

    rcsr_mod_counter #(.W(6), .LAST(`RCSR_SEC_LAST)) u_sec (
        .clock_in   (clock_in),
        .sys_rst_in (sys_rst_in),
        .clear_in   (adj_start),
        .step_in    (sec_step),
        .count_out  (sec_val),
        .carry_out  (sec_carry)
    );

    rcsr_mod_counter #(.W(6), .LAST(`RCSR_MIN_LAST)) u_min (
        .clock_in   (clock_in),
        .sys_rst_in (sys_rst_in),
        .clear_in   (1'b0),
        .step_in    (min_step),
        .count_out  (),
        .carry_out  (hour_carry)
    );

    // ======================================================================
    // Periodic output and interrupt flag
    logic         active;
    logic [20:0]  pulse_cnt;
    // Events fire on the carry into the selected digit
    wire          ev_sel     = ce.per_hi ? (ce.per_lo ? hour_carry : min_step)
                                         : (ce.per_lo ? sec_step : ev_64);
    wire          flag_set   = ev_sel & !ce.mask & !active;
    // Timeout pauses while rounding keeps the 1/64 carries away
    wire          pulse_done = !ce.irq_mode & active & !adj_busy
                               & (pulse_cnt == 21'h1);
    wire          flag_clr   = (wr_cd & !wd[`RCSR_CD_IRQ]) | pulse_done | ce.mask;

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            active <= 1'b0;
        end else if (flag_set) begin
            active <= 1'b1;
        end else if (flag_clr) begin
            active <= 1'b0;
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            pulse_cnt <= 21'h0;
        end else if (flag_set) begin
            pulse_cnt <= 21'(PULSE_CYC);
        end else if (active && !adj_busy && pulse_cnt != 21'h0) begin
            pulse_cnt <= pulse_cnt - 21'h1;
        end
    end

    // Open drain: only ever pulls low
    assign periodic_output_pin_out = 1'b0;
    assign periodic_output_pin_oe_out = active;

    // ======================================================================
    // Read data
    wire [3:0] rd_cd  = {adj_busy, active, busy, hold};
    wire [3:0] rd_mux = (addr_l == `RCSR_ADDR_CD) ? rd_cd :
                        (addr_l == `RCSR_ADDR_CE) ? 4'(ce) :
                        (addr_l == `RCSR_ADDR_CF) ? 4'(cf) : 4'h0;

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            bus_data_out <= 4'h0;
        end else begin
            bus_data_out <= rd_mux;
        end
    end

    assign bus_data_oe_out = rd_hit;

    // ======================================================================
    // Checks
    logic [14:0]  adj_len;
    logic [20:0]  pulse_len;

    always_ff @(posedge clock_in) begin
        if (sys_rst_in || !adj_busy) begin
            adj_len <= 15'h0;
        end else begin
            adj_len <= adj_len + 15'h1;
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in || !active || ce.irq_mode) begin
            pulse_len <= 21'h0;
        end else if (!adj_busy) begin
            pulse_len <= pulse_len + 21'h1;
        end
    end

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);

    sequence grant_seq;
        wr_cd && wd[`RCSR_CD_HOLD] && !hold && !win_busy && p2.cs1;
    endsequence

    sequence unmasked_ev_seq;
        ev_sel && !ce.mask && !active;
    endsequence

    hold_grant_a: assert property (grant_seq |=> hold && !busy)
        else $error("hold not granted outside busy window");
    hold_carry_a: assert property (hold && ev_sec |-> !sec_step)
        else $error("seconds carry passed during hold");
    hold_drop_a: assert property (!p2.cs1 |=> !hold && busy)
        else $error("hold survived power-good low");
    busy_free_a: assert property (!hold |-> rd_cd[`RCSR_CD_BUSY])
        else $error("busy reads zero with hold clear");
    flag_pin_a: assert property (rd_cd[`RCSR_CD_IRQ] == periodic_output_pin_oe_out)
        else $error("flag and pin disagree");
    event_set_a: assert property (unmasked_ev_seq |=> periodic_output_pin_oe_out)
        else $error("unmasked event did not pull pin low");
    irq_keep_a: assert property (active && ce.irq_mode && !ce.mask
                                 && !(wr_cd && !wd[`RCSR_CD_IRQ]) |=> active)
        else $error("interrupt flag dropped without clear");
    pulse_width_a: assert property (pulse_len <= 21'(PULSE_CYC))
        else $error("pulse held past its width");
    adj_length_a: assert property ($fell(adj_busy) |-> adj_len == 15'(ADJ_CYC))
        else $error("round bit length wrong");
    mask_open_a: assert property (ce.mask |-> !periodic_output_pin_oe_out)
        else $error("pin driven while masked");
    clr_drop_a: assert property (!p2.cs1 |=> !cf.clr)
        else $error("divider clear survived power-good low");
    stop_freeze_a: assert property (cf.stop && !sub_hold |=> $stable(sub[14:2]))
        else $error("chain advanced while stopped");
    format_lock_a: assert property (wr_cf && !cf.clr |=> $stable(cf.hour24))
        else $error("hour format changed without clear");

endmodule // rcsr_top
